// [tca_tx_cal_alarm.sv]
// Purpose: Transmit VCO sweep selection, transmit soft reset and transmit alarm status.
// Assumes: Register port signals, FIFO events and counter values come from core_clk logic.
// Notes:   Analogue detector levels arrive as pins and pass the three-stage synchroniser.

`timescale 1ns/1ps

module tca_tx_cal_alarm #(
  parameter int CNT_W = 8
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             ref_clock_loss_pin,
  input  wire logic             input_signal_loss_pin,
  input  wire logic             pll_unlock_pin,
  input  wire logic             ref_clock_present_pin,
  input  wire logic             pattern_sync_pin,
  input  wire logic             fifo_overflow,
  input  wire logic             fifo_underflow,
  input  wire logic             fifo_self_clear_enable,
  input  wire logic             pattern_checker_enable,
  input  wire logic [CNT_W-1:0] pattern_error_count,
  input  wire logic [CNT_W-1:0] pattern_error_threshold,
  input  wire logic [CNT_W-1:0] quality_value,
  input  wire logic [CNT_W-1:0] quality_threshold,
  output logic      [1:0]       vco_sweep_select,
  output logic                  vco_center_on_ref,
  output logic                  vco_full_sweep,
  output logic                  lock_loss,
  output logic                  tx_soft_reset,
  output logic      [7:0]       tx_alarm_flags
);

  // Refuse sizes that the comparators and the eight-bit reset counter cannot serve.
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
    $error("tca_tx_cal_alarm supports counter widths of 1 to 16 bits");
  end
  if (tca_pkg::SOFT_RESET_CYCLES < 2 || tca_pkg::SOFT_RESET_CYCLES > 255) begin : g_bad_reset
    $error("tca_tx_cal_alarm soft reset length out of range");
  end

  //////////////////////////////////////////////////////////////////////////////////////////////

  typedef enum logic {TCA_IDLE, TCA_RESETTING} tca_reset_state_t;

  localparam logic [7:0] RESET_LAST = 8'(tca_pkg::SOFT_RESET_CYCLES - 1);

  tca_reset_state_t reset_state;
  tca_reset_state_t next_reset_state;
  logic [7:0]       reset_count;
  logic [4:0]       pin_level;
  logic             ref_loss_s;
  logic             signal_loss_s;
  logic             pll_unlock_s;
  logic             ref_present_s;
  logic             sync_lost_s;

  tca_pin_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .pin_in    ({ref_clock_present_pin, pattern_sync_pin, pll_unlock_pin,
                 input_signal_loss_pin, ref_clock_loss_pin}),
    .level_out (pin_level)
  );

  assign ref_loss_s    = pin_level[0];
  assign signal_loss_s = pin_level[1];
  assign pll_unlock_s  = pin_level[2];
  assign sync_lost_s   = pin_level[3];
  assign ref_present_s = pin_level[4];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  wire cfg_write   = reg_wr && (reg_addr == tca_pkg::CAL_CONFIG_ADDR);
  wire soft_busy   = (reset_state == TCA_RESETTING);
  wire reset_start = cfg_write && reg_wdata[tca_pkg::SOFT_RESET_BIT] && !soft_busy;
  wire sweep_load  = cfg_write && !reg_wdata[tca_pkg::SOFT_RESET_BIT] && !soft_busy;
  wire reset_done  = soft_busy && (reset_count == 8'h00);

  // Writes landing while the reset runs are dropped, since that reset would undo them anyway.
  wire [1:0] next_sweep = (reset_start || soft_busy) ? tca_pkg::SWEEP_RESET :
                          sweep_load ? reg_wdata[tca_pkg::SWEEP_MSB:tca_pkg::SWEEP_LSB] :
                          vco_sweep_select;

  wire [7:0] cfg_view = {5'h00, vco_sweep_select, tx_soft_reset};

  // Alarm writes are not decoded at all, so writes to that register are ignored.
  wire [7:0] next_rdata = !reg_rd ? reg_rdata :
                          (reg_addr == tca_pkg::CAL_CONFIG_ADDR) ? cfg_view :
                          (reg_addr == tca_pkg::ALARM_ADDR) ? tx_alarm_flags :
                          8'h00;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Soft reset sequencer.

  always_comb begin
    next_reset_state = reset_state;
    case (reset_state)
      TCA_IDLE: begin
        if (reset_start) begin
          next_reset_state = TCA_RESETTING;
        end
      end
      TCA_RESETTING: begin
        if (reset_done) begin
          next_reset_state = TCA_IDLE;
        end
      end
      default: next_reset_state = TCA_IDLE;
    endcase
  end

  wire [7:0] next_reset_count = reset_start ? RESET_LAST :
                                (soft_busy && !reset_done) ? reset_count - 8'h01 :
                                reset_count;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reset_state   <= TCA_IDLE;
      reset_count   <= 8'h00;
      tx_soft_reset <= 1'b0;
    end else begin
      reset_state   <= next_reset_state;
      reset_count   <= next_reset_count;
      tx_soft_reset <= (next_reset_state == TCA_RESETTING);
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // VCO sweep control.

  wire sel_auto    = (vco_sweep_select == tca_pkg::SWEEP_AUTO);
  wire sel_invalid = (vco_sweep_select == tca_pkg::SWEEP_INVALID);
  wire next_center = (vco_sweep_select == tca_pkg::SWEEP_REFERENCE) ||
                     (sel_auto && ref_present_s);
  wire next_full   = (vco_sweep_select == tca_pkg::SWEEP_FULL) ||
                     (sel_auto && !ref_present_s);

  // The invalid setting drives neither sweep request, so the loop never claims lock.
  wire next_lock_loss = pll_unlock_s || sel_invalid;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      vco_sweep_select  <= tca_pkg::SWEEP_RESET;
      vco_center_on_ref <= 1'b0;
      vco_full_sweep    <= 1'b0;
      lock_loss         <= 1'b0;
    end else begin
      vco_sweep_select  <= next_sweep;
      vco_center_on_ref <= next_center;
      vco_full_sweep    <= next_full;
      lock_loss         <= next_lock_loss;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Alarm status.

  wire fifo_event = fifo_overflow || fifo_underflow;
  wire fifo_hold  = tx_alarm_flags[tca_pkg::FIFO_ERROR_BIT] && !fifo_self_clear_enable
                    && !soft_busy;
  // A new slip wins over both the self clear and the soft reset.
  wire next_fifo  = fifo_event || fifo_hold;

  wire [7:0] next_alarm = {1'b0,
                           ref_loss_s,
                           signal_loss_s,
                           next_lock_loss,
                           next_fifo,
                           pattern_error_count >= pattern_error_threshold,
                           pattern_checker_enable && sync_lost_s,
                           quality_value >= quality_threshold};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_alarm_flags <= tca_pkg::ALARM_RESET;
      reg_rdata      <= 8'h00;
    end else begin
      tx_alarm_flags <= next_alarm;
      reg_rdata      <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sweep_load_a: assert property (sweep_load |=>
      vco_sweep_select == $past(reg_wdata[tca_pkg::SWEEP_MSB:tca_pkg::SWEEP_LSB]))
    else $error("Sweep selector did not take the written value");

  auto_mode_a: assert property ((sel_auto && ref_present_s) |=>
      vco_center_on_ref && !vco_full_sweep)
    else $error("Automatic mode ignored the present reference");

  full_sweep_a: assert property ((vco_sweep_select == tca_pkg::SWEEP_FULL) |=>
      vco_full_sweep && !vco_center_on_ref)
    else $error("Referenceless mode did not sweep the full range");

  ref_centre_a: assert property ((vco_sweep_select == tca_pkg::SWEEP_REFERENCE) |=>
      vco_center_on_ref && !vco_full_sweep)
    else $error("Reference mode did not centre on the reference");

  invalid_lock_a: assert property (sel_invalid |=>
      lock_loss && tx_alarm_flags[4] && !vco_center_on_ref && !vco_full_sweep)
    else $error("Invalid sweep setting did not hold lock loss");

  soft_reset_a: assert property (reset_start |=>
      tx_soft_reset[*8] ##1 tx_soft_reset[*8] ##1 !tx_soft_reset)
    else $error("Soft reset bit did not clear after its span");

  reset_sweep_a: assert property (tx_soft_reset |->
      vco_sweep_select == tca_pkg::SWEEP_RESET)
    else $error("Sweep selector not at reset value during soft reset");

  ref_loss_a: assert property ($rose(ref_loss_s) |=> tx_alarm_flags[6])
    else $error("Reference loss not reported");

  signal_loss_a: assert property (signal_loss_s |=> tx_alarm_flags[5])
    else $error("Input signal loss not reported");

  pll_lock_a: assert property (pll_unlock_s |=> lock_loss && tx_alarm_flags[4])
    else $error("PLL lock loss not reported");

  fifo_set_a: assert property (fifo_event |=> tx_alarm_flags[3])
    else $error("FIFO slip did not set its alarm");

  fifo_clear_a: assert property ((tx_alarm_flags[3] && fifo_self_clear_enable
      && !fifo_event) |=> !tx_alarm_flags[3])
    else $error("FIFO alarm did not clear itself");

  pattern_limit_a: assert property (
      (pattern_error_count >= pattern_error_threshold) |=> tx_alarm_flags[2])
    else $error("Pattern error limit not reported");

  sync_gate_a: assert property (!pattern_checker_enable |=> !tx_alarm_flags[1])
    else $error("Pattern sync loss shown with checker off");

  quality_a: assert property ((quality_value >= quality_threshold) |=>
      tx_alarm_flags[0])
    else $error("Quality monitor alarm not reported");

  alarm_read_a: assert property ((reg_rd && reg_addr == tca_pkg::ALARM_ADDR) |=>
      reg_rdata == $past(tx_alarm_flags) && !reg_rdata[7])
    else $error("Alarm read returned wrong data");

  auto_sweep_a: assert property ((sel_auto && !ref_present_s) |=>
      vco_full_sweep && !vco_center_on_ref)
    else $error("Automatic mode did not sweep without a reference");

  cfg_read_a: assert property ((reg_rd && reg_addr == tca_pkg::CAL_CONFIG_ADDR) |=>
      reg_rdata == {5'h00, $past(vco_sweep_select), $past(tx_soft_reset)})
    else $error("Calibration config read returned wrong data");

  // A write that lands during the soft reset must not disturb the selector.
  busy_write_a: assert property ((cfg_write && soft_busy) |=>
      vco_sweep_select == tca_pkg::SWEEP_RESET)
    else $error("Write during soft reset changed the selector");

  fifo_sticky_a: assert property ((tx_alarm_flags[tca_pkg::FIFO_ERROR_BIT]
      && !fifo_self_clear_enable && !soft_busy) |=> tx_alarm_flags[tca_pkg::FIFO_ERROR_BIT])
    else $error("Sticky FIFO alarm dropped without a clear");

  soft_fifo_a: assert property ((soft_busy && !fifo_event) |=>
      !tx_alarm_flags[tca_pkg::FIFO_ERROR_BIT])
    else $error("Soft reset did not clear the FIFO alarm");

  ref_clear_a: assert property (!ref_loss_s |=>
      !tx_alarm_flags[tca_pkg::REF_LOSS_BIT])
    else $error("Reference loss shown without a loss");

  lock_clear_a: assert property ((!pll_unlock_s && !sel_invalid) |=>
      !lock_loss && !tx_alarm_flags[tca_pkg::LOCK_LOSS_BIT])
    else $error("Lock loss shown while locked");

  pattern_clear_a: assert property (
      (pattern_error_count < pattern_error_threshold) |=>
      !tx_alarm_flags[tca_pkg::PATTERN_LIMIT_BIT])
    else $error("Pattern error limit shown below the limit");

  sync_show_a: assert property ((pattern_checker_enable && sync_lost_s) |=>
      tx_alarm_flags[tca_pkg::PATTERN_SYNC_BIT])
    else $error("Pattern sync loss not shown with checker on");

  quality_clear_a: assert property ((quality_value < quality_threshold) |=>
      !tx_alarm_flags[tca_pkg::QUALITY_BIT])
    else $error("Quality alarm shown below the threshold");

  top_bit_a: assert property (!tx_alarm_flags[7])
    else $error("Reserved alarm bit read as one");

  soft_reset_c: cover property (reset_start ##1 tx_soft_reset [*8]);
  invalid_mode_c: cover property (sweep_load && reg_wdata[2:1] == 2'h3);
  fifo_clear_c: cover property (fifo_event ##1 fifo_self_clear_enable ##1 !tx_alarm_flags[3]);
  auto_ref_c: cover property ((sel_auto && ref_present_s) ##1 vco_center_on_ref);
  sync_show_c: cover property ((pattern_checker_enable && sync_lost_s) ##1 tx_alarm_flags[1]);

endmodule // tca_tx_cal_alarm

// [tca_pkg.sv]
// Purpose: Constants for the transmit calibration control and alarm status block.
// Assumes: Registers are reached through the device's own byte-wide register port.
// Notes:   Offsets are the register numbers of the management map.
//
// Behaviour
// - The two-bit VCO sweep selector is held in bits 2:1 of the calibration config register.
// - Selector 00 centres the VCO on a present reference and otherwise sweeps the whole range.
// - Selector 01 always sweeps the whole VCO range, reference or not.
// - Selector 10 centres the VCO pull range on the reference frequency.
// - Selector 11 is invalid and keeps the transmit lock-loss indication asserted.
// - Writing one to bit 0 resets the transmit registers; the bit clears itself when done.
// - Bit 6 of the alarm register reports a coarse reference clock frequency loss.
// - Bit 5 of the alarm register reports loss of signal on the transmit serial input.
// - Bit 4 of the alarm register reports that the transmit PLL lost lock to its input.
// - Bit 3 of the alarm register is set on a transmit FIFO overflow or underflow.
// - With FIFO self clearing enabled the FIFO error bit clears itself after the event.
// - Bit 2 of the alarm register is set once the pattern error count reaches its limit.
// - Bit 1 reads zero with the pattern checker off and otherwise shows pattern sync loss.
// - Bit 0 of the alarm register is set when the quality monitor value meets its threshold.

package tca_pkg;

  localparam logic [7:0] CAL_CONFIG_ADDR    = 8'h88;
  localparam logic [7:0] ALARM_ADDR         = 8'h89;

  localparam int         SOFT_RESET_BIT     = 0;
  localparam int         SWEEP_LSB          = 1;
  localparam int         SWEEP_MSB          = 2;

  localparam int         REF_LOSS_BIT       = 6;
  localparam int         SIGNAL_LOSS_BIT    = 5;
  localparam int         LOCK_LOSS_BIT      = 4;
  localparam int         FIFO_ERROR_BIT     = 3;
  localparam int         PATTERN_LIMIT_BIT  = 2;
  localparam int         PATTERN_SYNC_BIT   = 1;
  localparam int         QUALITY_BIT        = 0;

  localparam logic [1:0] SWEEP_AUTO         = 2'h0;
  localparam logic [1:0] SWEEP_FULL         = 2'h1;
  localparam logic [1:0] SWEEP_REFERENCE    = 2'h2;
  localparam logic [1:0] SWEEP_INVALID      = 2'h3;
  localparam logic [1:0] SWEEP_RESET        = SWEEP_AUTO;

  localparam logic [7:0] ALARM_RESET        = 8'h00;

  localparam int         CLK_PERIOD_PS      = 10000;
  localparam int         SOFT_RESET_NS      = 160;
  localparam int         SOFT_RESET_CYCLES  = (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;

endpackage : tca_pkg

// [tca_pin_sync.sv]
// Purpose: Three-stage synchroniser for a group of asynchronous pin inputs.
// Assumes: Each pin is a slow level; pulses shorter than two clocks may be missed.
// Notes:   The output only follows once the second and third stages agree.

`timescale 1ns/1ps

module tca_pin_sync #(
  parameter int WIDTH = 5
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("tca_pin_sync needs at least one pin");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic stage1;
    logic stage2;
    logic stage3;

    // Stage one feeds stage two only; the agreement test looks at two and three.
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        stage1       <= 1'b0;
        stage2       <= 1'b0;
        stage3       <= 1'b0;
        level_out[i] <= 1'b0;
      end else begin
        stage1 <= pin_in[i];
        stage2 <= stage1;
        stage3 <= stage2;
        if (stage2 == stage3) begin
          level_out[i] <= stage3;
        end
      end
    end
  end

endmodule // tca_pin_sync

// [testbench.sv]
// Purpose: Self-checking bench for the transmit sweep select, soft reset and alarm block.
// Assumes: Inputs change at the falling edge; pin levels are held long enough to pass the sync.
// Notes:   Register reads are noted in a queue and checked by a separate monitor process.

`timescale 1ns/1ps

module testbench;
  logic       core_clk                = 1'b0;
  logic       sys_rst                 = 1'b1;
  logic [7:0] reg_addr                = 8'h00;
  logic [7:0] reg_wdata               = 8'h00;
  logic       reg_wr                  = 1'b0;
  logic       reg_rd                  = 1'b0;
  logic       rd_seen                 = 1'b0;
  logic [4:0] pins                    = 5'h00;
  logic       fifo_overflow           = 1'b0;
  logic       fifo_underflow          = 1'b0;
  logic       fifo_self_clear_enable  = 1'b0;
  logic       pattern_checker_enable  = 1'b0;
  logic [7:0] pattern_error_count     = 8'h00;
  logic [7:0] pattern_error_threshold = 8'hff;
  logic [7:0] quality_value           = 8'h00;
  logic [7:0] quality_threshold       = 8'hff;
  logic [1:0] cur_sel                 = 2'h0;
  logic [7:0] exp_a;
  logic       exp_c;
  logic       exp_f;
  logic [7:0] reg_rdata;
  logic [7:0] tx_alarm_flags;
  logic [1:0] vco_sweep_select;
  logic       vco_center_on_ref;
  logic       vco_full_sweep;
  logic       lock_loss;
  logic       tx_soft_reset;
  logic [7:0] rd_q[$];
  int         num_errors              = 0;
  int         comparisons             = 0;
  int         n;

  always #5 core_clk = ~core_clk;

  // Pin order: reference loss, signal loss, PLL unlock, reference present, pattern sync.
  tca_tx_cal_alarm #(.CNT_W(8)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ref_clock_loss_pin(pins[4]), .input_signal_loss_pin(pins[3]), .pll_unlock_pin(pins[2]),
    .ref_clock_present_pin(pins[1]), .pattern_sync_pin(pins[0]),
    .fifo_overflow(fifo_overflow), .fifo_underflow(fifo_underflow),
    .fifo_self_clear_enable(fifo_self_clear_enable),
    .pattern_checker_enable(pattern_checker_enable),
    .pattern_error_count(pattern_error_count), .pattern_error_threshold(pattern_error_threshold),
    .quality_value(quality_value), .quality_threshold(quality_threshold),
    .vco_sweep_select(vco_sweep_select), .vco_center_on_ref(vco_center_on_ref),
    .vco_full_sweep(vco_full_sweep), .lock_loss(lock_loss), .tx_soft_reset(tx_soft_reset),
    .tx_alarm_flags(tx_alarm_flags)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    if (rd_q.size() != 0) begin
      num_errors++;
      $display("Error read queue expected 0 seen %0d", rd_q.size());
    end
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic idle(int cycles);
    repeat (cycles) @(negedge core_clk);
  endtask

  // Only the two registers of this block are written and no loopback is ever set up.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    rd_q.push_back(e);
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask

  function automatic logic [7:0] alarm_exp(logic fifo_bit);
    return {1'b0, pins[4], pins[3], pins[2] | (cur_sel == 2'h3), fifo_bit,
            pattern_error_count >= pattern_error_threshold,
            pattern_checker_enable & pins[0], quality_value >= quality_threshold};
  endfunction

  // Read data is valid right after the edge that took the read strobe.
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_seen && rd_q.size() > 0) begin
      cmp("read data", rd_q.pop_front(), reg_rdata);
    end else if (rd_seen) begin
      num_errors++;
      $display("Error read data expected a queued value seen %h", reg_rdata);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h89334c79));
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(8'h88, 8'h00);
    rd(8'h89, 8'h00);
    rd(8'h40, 8'h00);
    $display("test reset values done");

    // Each selector is tried with and without a reference present.
    for (int p = 0; p < 2; p++) begin
      pins[1] = p[0];
      idle(6);
      for (int s = 0; s < 4; s++) begin
        cur_sel = s[1:0];
        wr(8'h88, {5'h00, cur_sel, 1'b0});
        idle(2);
        cmp("sweep select", {6'h00, cur_sel}, {6'h00, vco_sweep_select});
        exp_c = (s == 2) || (s == 0 && p == 1);
        exp_f = (s == 1) || (s == 0 && p == 0);
        cmp("centre", {7'h00, exp_c}, {7'h00, vco_center_on_ref});
        cmp("full sweep", {7'h00, exp_f}, {7'h00, vco_full_sweep});
        cmp("lock loss", {7'h00, s == 3}, {7'h00, lock_loss});
        rd(8'h88, {5'h00, cur_sel, 1'b0});
        rd(8'h89, alarm_exp(1'b0));
      end
    end
    $display("test sweep modes done");

    wr(8'h88, 8'h05);
    cur_sel = 2'h0;
    cmp("soft reset", 8'h01, {7'h00, tx_soft_reset});
    wr(8'h88, 8'h04);
    rd(8'h88, 8'h01);
    n = 4;
    while (tx_soft_reset === 1'b1 && n < 40) begin
      n++;
      @(negedge core_clk);
    end
    cmp("soft reset length", 8'(tca_pkg::SOFT_RESET_CYCLES), n[7:0]);
    cmp("sweep after reset", 8'h00, {6'h00, vco_sweep_select});
    rd(8'h88, 8'h00);
    $display("test soft reset done");

    // Sticky FIFO alarm first, then the self-clearing variant.
    @(negedge core_clk);
    fifo_overflow = 1'b1;
    @(negedge core_clk);
    fifo_overflow = 1'b0;
    idle(3);
    rd(8'h89, alarm_exp(1'b1));
    wr(8'h88, 8'h01);
    idle(18);
    rd(8'h89, alarm_exp(1'b0));
    fifo_self_clear_enable = 1'b1;
    @(negedge core_clk);
    fifo_underflow = 1'b1;
    @(negedge core_clk);
    fifo_underflow = 1'b0;
    cmp("fifo alarm set", alarm_exp(1'b1), tx_alarm_flags);
    @(negedge core_clk);
    cmp("fifo alarm cleared", alarm_exp(1'b0), tx_alarm_flags);
    $display("test fifo alarm done");

    // Random pins and counts; the first pass sits exactly on both thresholds.
    for (int i = 0; i < 12; i++) begin
      pins = 5'($urandom());
      pattern_checker_enable = 1'($urandom());
      pattern_error_count = 8'($urandom());
      quality_value = 8'($urandom());
      pattern_error_threshold = (i == 0) ? pattern_error_count : 8'($urandom());
      quality_threshold = (i == 0) ? quality_value : 8'($urandom());
      wr(8'h89, 8'hff);
      idle(5);
      exp_a = alarm_exp(1'b0);
      cmp("alarm hi", exp_a & 8'h70, tx_alarm_flags & 8'h70);
      cmp("alarm fifo", exp_a & 8'h88, tx_alarm_flags & 8'h88);
      cmp("alarm lo", exp_a & 8'h07, tx_alarm_flags & 8'h07);
      rd(8'h89, alarm_exp(1'b0));
    end
    $display("test alarm bits done");
    // Let the monitor take the last read before the verdict.
    idle(2);
    conclude();
  end
endmodule // testbench
